// File: core/rtc_core.sv
// Purpose: Seconds counter with time-of-day and sub-second alarms
// Assumes: Control bits are plain ports, pulses last one cycle
// Notes: Alarm flags are sticky; set beats clear
//
// Summary of operation
// - Time is a 32-bit seconds count advancing once per second.
// - A time-of-day alarm fires 1 s to 12 days after it is set.
// - An independent 32-bit sub-second alarm counts 1/4096 s units, 244 us to 12 days.
// - Either alarm can be made recurring so it fires each interval.
// - An expired enabled alarm raises an interrupt or a wake request.
// - The time base comes from the 32.768 kHz crystal or an external clock by selection.
// - A trim of +/-127 ppm in 1 ppm steps adjusts the effective rate.
// - When enabled, a calibration signal from the time base is driven out.
`timescale 1ns/1ps
`default_nettype none
module rtc_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ext_low_freq_xtal_osc,
  input wire logic ext_clk_in,
  input wire logic src_ext,
  input wire logic [7:0] trim,
  input wire logic cal_en,
  output logic cal_clock_out,
  input wire logic time_wr,
  input wire logic [31:0] time_wsec,
  input wire logic [11:0] time_wsub,
  output logic [31:0] seconds,
  output logic [11:0] subsec,
  input wire logic tod_set,
  input wire logic [19:0] tod_interval,
  input wire logic tod_recur,
  input wire logic sub_set,
  input wire logic [31:0] sub_interval,
  input wire logic sub_recur,
  input wire logic [1:0] alarm_clr,
  input wire logic [1:0] irq_en,
  input wire logic [1:0] wake_en,
  output logic [1:0] alarm_flag,
  output logic tod_armed,
  output logic sub_armed,
  output logic irq,
  output logic wake_req
);
  import rtc_pkg::*;

  rtc_tick_if tk ();

  rtc_time_base u_tb (
    .clk(clk),
    .nrst(nrst),
    .ext_low_freq_xtal_osc(ext_low_freq_xtal_osc),
    .ext_clk_in(ext_clk_in),
    .src_ext(src_ext),
    .trim(trim),
    .cal_en(cal_en),
    .cal_clock_out(cal_clock_out),
    .tk(tk)
  );

  function automatic logic [19:0] clamp20(input logic [19:0] v);
    clamp20 = (v < TOD_IVL_MIN) ? TOD_IVL_MIN : ((v > TOD_IVL_MAX) ? TOD_IVL_MAX : v);
  endfunction

  function automatic logic [31:0] clamp32(input logic [31:0] v);
    clamp32 = (v < SUB_IVL_MIN) ? SUB_IVL_MIN : ((v > SUB_IVL_MAX) ? SUB_IVL_MAX : v);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Time counter
  logic [31:0] sec_reg, sec_next;
  logic [11:0] sub_reg, sub_next;
  logic sec_tick;

  always_comb begin
    sec_tick = tk.sub_tick && sub_reg == SUB_MAX;
    sub_next = sub_reg;
    sec_next = sec_reg;
    if (time_wr) begin
      sub_next = time_wsub;
      sec_next = time_wsec;
    end else if (tk.sub_tick) begin
      sub_next = sub_reg + 12'h001;
      if (sec_tick) begin
        sec_next = sec_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sec_reg <= SEC_RESET;
      sub_reg <= 12'h000;
    end else begin
      sec_reg <= sec_next;
      sub_reg <= sub_next;
    end
  end

  assign seconds = sec_reg;
  assign subsec = sub_reg;

  ////////////////////////////////////////////////////////////////////
  // Time-of-day alarm
  alarm_state_e tod_st_reg, tod_st_next;
  logic [31:0] tod_tgt_reg, tod_tgt_next;
  logic [19:0] tod_ivl_reg, tod_ivl_next;
  logic tod_rec_reg, tod_rec_next;
  logic tod_hit;

  always_comb begin
    tod_st_next = tod_st_reg;
    tod_tgt_next = tod_tgt_reg;
    tod_ivl_next = tod_ivl_reg;
    tod_rec_next = tod_rec_reg;
    tod_hit = 1'b0;
    unique case (tod_st_reg)
      ALM_IDLE: begin
      end
      ALM_ARMED: begin
        if (sec_tick && !time_wr && sec_next == tod_tgt_reg) begin
          tod_hit = 1'b1;
          if (tod_rec_reg) begin
            tod_tgt_next = tod_tgt_reg + {12'h000, tod_ivl_reg};
          end else begin
            tod_st_next = ALM_IDLE;
          end
        end
      end
    endcase
    if (tod_set) begin
      tod_ivl_next = clamp20(tod_interval);
      tod_tgt_next = sec_reg + {12'h000, clamp20(tod_interval)};
      tod_rec_next = tod_recur;
      tod_st_next = ALM_ARMED;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tod_st_reg <= ALM_IDLE;
      tod_tgt_reg <= 32'h0000_0000;
      tod_ivl_reg <= TOD_IVL_MIN;
      tod_rec_reg <= 1'b0;
    end else begin
      tod_st_reg <= tod_st_next;
      tod_tgt_reg <= tod_tgt_next;
      tod_ivl_reg <= tod_ivl_next;
      tod_rec_reg <= tod_rec_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sub-second alarm, down-counter in 1/4096 s units
  alarm_state_e sa_st_reg, sa_st_next;
  logic [31:0] sa_cnt_reg, sa_cnt_next;
  logic [31:0] sa_ivl_reg, sa_ivl_next;
  logic sa_rec_reg, sa_rec_next;
  logic sa_hit;

  always_comb begin
    sa_st_next = sa_st_reg;
    sa_cnt_next = sa_cnt_reg;
    sa_ivl_next = sa_ivl_reg;
    sa_rec_next = sa_rec_reg;
    sa_hit = 1'b0;
    unique case (sa_st_reg)
      ALM_IDLE: begin
      end
      ALM_ARMED: begin
        if (tk.sub_tick) begin
          if (sa_cnt_reg == SUB_IVL_MIN) begin
            sa_hit = 1'b1;
            if (sa_rec_reg) begin
              sa_cnt_next = sa_ivl_reg;
            end else begin
              sa_st_next = ALM_IDLE;
            end
          end else begin
            sa_cnt_next = sa_cnt_reg - 32'h0000_0001;
          end
        end
      end
    endcase
    if (sub_set) begin
      sa_ivl_next = clamp32(sub_interval);
      sa_cnt_next = clamp32(sub_interval);
      sa_rec_next = sub_recur;
      sa_st_next = ALM_ARMED;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sa_st_reg <= ALM_IDLE;
      sa_cnt_reg <= SUB_IVL_MIN;
      sa_ivl_reg <= SUB_IVL_MIN;
      sa_rec_reg <= 1'b0;
    end else begin
      sa_st_reg <= sa_st_next;
      sa_cnt_reg <= sa_cnt_next;
      sa_ivl_reg <= sa_ivl_next;
      sa_rec_reg <= sa_rec_next;
    end
  end

  assign tod_armed = tod_st_reg == ALM_ARMED;
  assign sub_armed = sa_st_reg == ALM_ARMED;

  ////////////////////////////////////////////////////////////////////
  // Sticky flags, bit 0 time-of-day, bit 1 sub-second
  logic [1:0] flag_reg, flag_next, hit;

  always_comb begin
    hit = {sa_hit, tod_hit};
    for (int i = 0; i < 2; i++) begin
      flag_next[i] = hit[i] | (flag_reg[i] & ~alarm_clr[i]);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag_reg <= 2'b00;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign alarm_flag = flag_reg;
  assign irq = |(flag_reg & irq_en);
  assign wake_req = |(flag_reg & wake_en);

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_wrap;
    tk.sub_tick && sub_reg == SUB_MAX && !time_wr;
  endsequence

  property p_sec_on_wrap;
    s_wrap |=> seconds == $past(seconds) + 32'h0000_0001 && subsec == 12'h000;
  endproperty
  a_sec_on_wrap: assert property (p_sec_on_wrap) else $error("seconds did not advance on wrap");

  property p_sec_hold;
    !time_wr && !(tk.sub_tick && sub_reg == SUB_MAX) |=> $stable(seconds);
  endproperty
  a_sec_hold: assert property (p_sec_hold) else $error("seconds moved without wrap");

  property p_tod_fire;
    tod_armed ##0 s_wrap ##0 (sec_next == tod_tgt_reg) |=> alarm_flag[0];
  endproperty
  a_tod_fire: assert property (p_tod_fire) else $error("tod alarm missed");

  property p_tod_target;
    tod_set |=> tod_tgt_reg == $past(sec_reg) + {12'h000, clamp20($past(tod_interval))};
  endproperty
  a_tod_target: assert property (p_tod_target) else $error("tod target wrong");

  property p_sub_fire;
    sub_armed && tk.sub_tick && sa_cnt_reg == SUB_IVL_MIN && !sub_set |=> alarm_flag[1];
  endproperty
  a_sub_fire: assert property (p_sub_fire) else $error("sub alarm missed");

  property p_sub_recur;
    sa_hit && sa_rec_reg && !sub_set |=> sub_armed && sa_cnt_reg == $past(sa_ivl_reg);
  endproperty
  a_sub_recur: assert property (p_sub_recur) else $error("recurring reload failed");

  property p_flag_sticky;
    flag_reg[0] && !alarm_clr[0] |=> flag_reg[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear");

  property p_irq_follow;
    irq == |(alarm_flag & irq_en) && wake_req == |(alarm_flag & wake_en);
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq or wake not following flags");
endmodule
`default_nettype wire

// File: common/rtc_pkg.sv
// Purpose: Shared constants for the seconds/alarm clock
// Assumes: 50 MHz system clock, 32.768 kHz time base
// Notes: Counts derived from times where a time is given
package rtc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int SUB_W = 12;
  localparam logic [11:0] SUB_MAX = 12'hFFF;
  localparam int SEC_W = 32;
  // Time base: 8 source edges per 1/4096 s at nominal rate
  localparam logic [23:0] NOM_STEP = 24'h0F_4240;
  localparam logic [23:0] TICK_THRESH = 24'h7A_1200;
  localparam logic signed [7:0] TRIM_MAX = 8'sh7F;
  // Alarm limits: 12 days in seconds and in 1/4096 s units
  localparam int unsigned ALARM_SPAN_S = 1036800;
  localparam logic [19:0] TOD_IVL_MIN = 20'h0_0001;
  localparam logic [19:0] TOD_IVL_MAX = 20'hF_D200;
  localparam logic [31:0] SUB_IVL_MIN = 32'h0000_0001;
  localparam logic [31:0] SUB_IVL_MAX = 32'hFD20_0000;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  localparam logic [23:0] ACC_RESET = 24'h00_0000;
  typedef enum logic {ALM_IDLE, ALM_ARMED} alarm_state_e;
endpackage

// File: common/rtc_tick_if.sv
// Purpose: Carries the sub-second tick from time base to counter
// Assumes: Single clock domain
// Notes: One-cycle pulse per 1/4096 s
`timescale 1ns/1ps
`default_nettype none
interface rtc_tick_if;
  logic sub_tick;
  modport src (output sub_tick);
  modport dst (input sub_tick);
endinterface
`default_nettype wire

// File: core/rtc_time_base.sv
// Purpose: Source select, trimmed divider to 4096 Hz, calibration output
// Assumes: Source inputs are synchronous levels sampled on clk
// Notes: Fractional accumulator, step 1e6 plus trim ppm per source edge
`timescale 1ns/1ps
`default_nettype none
module rtc_time_base (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ext_low_freq_xtal_osc,
  input wire logic ext_clk_in,
  input wire logic src_ext,
  input wire logic [7:0] trim,
  input wire logic cal_en,
  output logic cal_clock_out,
  rtc_tick_if.src tk
);
  import rtc_pkg::*;

  logic src_prev_reg, src_prev_next;
  logic [23:0] acc_reg, acc_next;
  logic tick_reg, tick_next;
  logic cal_reg, cal_next;
  logic sel, src_edge;
  logic signed [7:0] trim_c;
  logic [23:0] step, sum;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    sel = src_ext ? ext_clk_in : ext_low_freq_xtal_osc;
    src_edge = sel & ~src_prev_reg;
    src_prev_next = sel;
    // Clamp -128 to -127
    trim_c = ($signed(trim) < -TRIM_MAX) ? -TRIM_MAX : $signed(trim);
    step = NOM_STEP + {{16{trim_c[7]}}, trim_c};
    sum = src_edge ? (acc_reg + step) : acc_reg;
    tick_next = 1'b0;
    acc_next = sum;
    if (sum >= TICK_THRESH) begin
      acc_next = sum - TICK_THRESH;
      tick_next = 1'b1;
    end
    cal_next = tick_reg ? ~cal_reg : cal_reg;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      src_prev_reg <= 1'b0;
      acc_reg <= ACC_RESET;
      tick_reg <= 1'b0;
      cal_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_prev_next;
      acc_reg <= acc_next;
      tick_reg <= tick_next;
      cal_reg <= cal_next;
    end
  end

  assign tk.sub_tick = tick_reg;
  // 2048 Hz square wave carrying the trim
  assign cal_clock_out = cal_en & cal_reg;

  ////////////////////////////////////////////////////////////////////
  property p_tick_from_edge;
    @(posedge clk) disable iff (!nrst)
      tick_reg |-> $past(src_edge) || $past(tick_reg) == 1'b0 && $past(acc_reg) >= TICK_THRESH;
  endproperty
  a_tick_from_edge: assert property (p_tick_from_edge) else $error("tick without source edge");

  property p_trim_step;
    @(posedge clk) disable iff (!nrst)
      src_edge && !tick_next |=> acc_reg == $past(acc_reg) + $past(step);
  endproperty
  a_trim_step: assert property (p_trim_step) else $error("accumulator step wrong");

  property p_cal_gate;
    @(posedge clk) disable iff (!nrst)
      !cal_en |-> !cal_clock_out;
  endproperty
  a_cal_gate: assert property (p_cal_gate) else $error("cal output while disabled");
endmodule
`default_nettype wire

// File: tb/rtc_seconds_alarm_calibration_bench.sv
// Purpose: Self-checking bench for the seconds/alarm clock
// Assumes: Source edges two clocks apart, eight edges per sub tick at zero trim
// Notes: Time writes park the sub-count near wrap to keep runs short
`timescale 1ns/1ps
`default_nettype none
module rtc_seconds_alarm_calibration_bench;
  import rtc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic xtal = 1'b0;
  logic ext_clk = 1'b0;
  logic src_ext = 1'b0;
  logic [7:0] trim = 8'h00;
  logic cal_en = 1'b0;
  logic time_wr = 1'b0;
  logic [31:0] time_wsec = 32'h0000_0000;
  logic [11:0] time_wsub = 12'h000;
  logic tod_set = 1'b0;
  logic [19:0] tod_interval = 20'h0_0000;
  logic tod_recur = 1'b0;
  logic sub_set = 1'b0;
  logic [31:0] sub_interval = 32'h0000_0000;
  logic sub_recur = 1'b0;
  logic [1:0] alarm_clr = 2'h0;
  logic [1:0] irq_en = 2'h0;
  logic [1:0] wake_en = 2'h0;
  logic cal_clock_out, tod_armed, sub_armed, irq, wake_req;
  logic [31:0] seconds;
  logic [11:0] subsec;
  logic [1:0] alarm_flag;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;

  rtc_core dut (.clk(clk), .nrst(nrst), .ext_low_freq_xtal_osc(xtal), .ext_clk_in(ext_clk), .src_ext(src_ext),
    .trim(trim), .cal_en(cal_en), .cal_clock_out(cal_clock_out), .time_wr(time_wr), .time_wsec(time_wsec),
    .time_wsub(time_wsub), .seconds(seconds), .subsec(subsec), .tod_set(tod_set), .tod_interval(tod_interval),
    .tod_recur(tod_recur), .sub_set(sub_set), .sub_interval(sub_interval), .sub_recur(sub_recur),
    .alarm_clr(alarm_clr), .irq_en(irq_en), .wake_en(wake_en), .alarm_flag(alarm_flag), .tod_armed(tod_armed),
    .sub_armed(sub_armed), .irq(irq), .wake_req(wake_req));

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard, well above the several hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic edges(input logic use_ext, input int n);
    repeat (n) begin
      @(posedge clk);
      if (use_ext) ext_clk <= 1'b1;
      else xtal <= 1'b1;
      @(posedge clk);
      ext_clk <= 1'b0;
      xtal <= 1'b0;
    end
    wait_clk(5);
  endtask

  task automatic do_reset(input int n);
    @(posedge clk);
    nrst <= 1'b0;
    wait_clk(n);
    nrst <= 1'b1;
  endtask

  task automatic wr_time(input logic [31:0] s, input logic [11:0] f);
    @(posedge clk);
    time_wr <= 1'b1;
    time_wsec <= s;
    time_wsub <= f;
    @(posedge clk);
    time_wr <= 1'b0;
    wait_clk(1);
  endtask

  task automatic set_tod(input logic [19:0] ivl, input logic rec);
    @(posedge clk);
    tod_set <= 1'b1;
    tod_interval <= ivl;
    tod_recur <= rec;
    @(posedge clk);
    tod_set <= 1'b0;
    wait_clk(1);
  endtask

  task automatic set_sub(input logic [31:0] ivl, input logic rec);
    @(posedge clk);
    sub_set <= 1'b1;
    sub_interval <= ivl;
    sub_recur <= rec;
    @(posedge clk);
    sub_set <= 1'b0;
    wait_clk(1);
  endtask

  task automatic clr(input logic [1:0] b);
    @(posedge clk);
    alarm_clr <= b;
    @(posedge clk);
    alarm_clr <= 2'h0;
    wait_clk(1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_cal();
    chk("time after reset", 32'h0000_0000, seconds | {20'h0_0000, subsec});
    chk("flags after reset", 32'h0000_0000, {alarm_flag, tod_armed, sub_armed, irq, wake_req, cal_clock_out});
    @(posedge clk);
    cal_en <= 1'b1;
    wait_clk(2);
    chk("cal out", 32'h0000_0000, cal_clock_out);
    edges(1'b0, 8);
    chk("cal out", 32'h0000_0001, cal_clock_out);
    edges(1'b0, 8);
    chk("cal out", 32'h0000_0000, cal_clock_out);
    @(posedge clk);
    cal_en <= 1'b0;
    edges(1'b0, 8);
    chk("cal out", 32'h0000_0000, cal_clock_out);
    $display("reset and calibration output done");
  endtask

  task automatic t_count();
    wr_time(32'h1234_5678, 12'hFFE);
    edges(1'b0, 7);
    chk("subsec", 32'h0000_0FFE, subsec);
    edges(1'b0, 1);
    chk("subsec", 32'h0000_0FFF, subsec);
    chk("seconds", 32'h1234_5678, seconds);
    edges(1'b0, 8);
    chk("wrap", 32'h1234_5679, seconds ^ {20'h0_0000, subsec});
    wr_time(32'hFFFF_FFFF, 12'hFFF);
    edges(1'b0, 8);
    chk("seconds", 32'h0000_0000, seconds);
    @(posedge clk);
    src_ext <= 1'b1;
    edges(1'b0, 8);
    chk("subsec", 32'h0000_0000, subsec);
    edges(1'b1, 8);
    chk("subsec", 32'h0000_0001, subsec);
    @(posedge clk);
    src_ext <= 1'b0;
    edges(1'b1, 8);
    chk("subsec", 32'h0000_0001, subsec);
    $display("counting and source select done");
  endtask

  task automatic t_trim();
    logic [7:0] tv [2] = '{8'h81, 8'h80};
    for (int i = 0; i < 2; i++) begin
      do_reset(2);
      trim <= tv[i];
      edges(1'b0, 8);
      chk("subsec slow", 32'h0000_0000, subsec);
      edges(1'b0, 1);
      chk("subsec slow", 32'h0000_0001, subsec);
    end
    @(posedge clk);
    trim <= 8'h00;
    do_reset(2);
    $display("trim done");
  endtask

  task automatic t_tod();
    @(posedge clk);
    irq_en <= 2'h1;
    wr_time(32'h0000_0064, 12'hFFF);
    set_tod(20'h0_0002, 1'b0);
    chk("tod armed", 32'h0000_0001, tod_armed);
    edges(1'b0, 8);
    chk("flags", 32'h0000_0000, alarm_flag);
    wr_time(32'h0000_0065, 12'hFFF);
    edges(1'b0, 8);
    chk("tod fire", 32'h0000_0005, {alarm_flag, tod_armed, irq});
    wr_time(32'h0000_0066, 12'hFFF);
    edges(1'b0, 8);
    chk("flags sticky", 32'h0000_0001, alarm_flag);
    clr(2'h1);
    chk("cleared", 32'h0000_0000, {alarm_flag, irq});
    set_tod(20'h0_0000, 1'b1);
    for (int i = 0; i < 2; i++) begin
      wr_time(32'h0000_0067 + i, 12'hFFF);
      edges(1'b0, 8);
      chk("tod recur", 32'h0000_0003, {alarm_flag, tod_armed});
      clr(2'h1);
    end
    do_reset(2);
    set_tod(20'hF_FFFF, 1'b0);
    wr_time(32'h000F_D1FE, 12'hFFF);
    edges(1'b0, 8);
    chk("tod far", 32'h0000_0000, alarm_flag);
    wr_time(32'h000F_D1FF, 12'hFFF);
    edges(1'b0, 8);
    chk("tod far", 32'h0000_0001, alarm_flag);
    @(posedge clk);
    irq_en <= 2'h0;
    wake_en <= 2'h1;
    wait_clk(1);
    chk("irq wake", 32'h0000_0001, {irq, wake_req});
    do_reset(2);
    $display("time-of-day alarm done");
  endtask

  task automatic t_sub();
    @(posedge clk);
    wake_en <= 2'h2;
    set_sub(32'h0000_0003, 1'b0);
    chk("sub armed", 32'h0000_0001, sub_armed);
    edges(1'b0, 16);
    chk("flags", 32'h0000_0000, alarm_flag);
    edges(1'b0, 8);
    chk("sub fire", 32'h0000_0011, {alarm_flag, sub_armed, irq, wake_req});
    clr(2'h2);
    set_sub(32'h0000_0000, 1'b1);
    @(posedge clk);
    irq_en <= 2'h2;
    for (int i = 0; i < 2; i++) begin
      edges(1'b0, 8);
      chk("sub recur", 32'h0000_000B, {alarm_flag, sub_armed, irq});
      clr(2'h2);
    end
    $display("sub-second alarm done");
  endtask

  initial begin
    wait_clk(20);
    nrst <= 1'b1;
    t_reset_cal();
    t_count();
    t_trim();
    t_tod();
    t_sub();
    give_verdict();
  end
endmodule
`default_nettype wire
